// file: bridge_ctrl.sv
// Bridge end: straps, PCI arbiter, configuration selects, clock control
// Operation
// - Sample straps at reset, apply afterwards
// - Unstrapped host frequency selects 66 MHz
// - Unstrapped queue strap gives depth eight
// - Quick-start strap high enables quick start
// - Graphics disable strap high disables port
// - Unstrapped memory config gives standard mode
// - Buffer strap high selects front-side buffers
// - Support PCI clock stop and restart
// - Agent holds clock-run low when needing clock
// - Arbitrate up to five masters, pairs
// - Configuration only by mechanism one
// - Bridge is device zero, bit 11 never
// - Bit 12 graphics, externals from 13
// - Southbridge should use bit 18
// - Gate internal clock when fully idle
// - Stop second-level SRAM clock in stop mode
// - Cache is 512K direct-mapped write-back
// - Extended mode caches management memory 1M
// - Six SDRAM banks, one enable each
// - Standard mode lacks eight banks, 100 MHz
// - All rows one technology, never mixed
module bridge_ctrl
    import bridge_ctrl_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST,
    bridge_link_if.bridge LINK,
    input wire logic HOST_ACTIVITY,
    input wire logic STOP_CLOCK_REQ,
    input wire logic CFG_REQ,
    input wire logic [4:0] CFG_DEVICE,
    input wire logic [NUM_BANKS-1:0] BANK_ENABLE,
    output logic HOST_FREQ_66,
    output logic [3:0] QUEUE_DEPTH,
    output logic QUICK_START,
    output logic GRAPHICS_ENABLE,
    output logic STANDARD_MEM_MODE,
    output logic FSB_BUFFERS,
    output logic PCI_CLOCK_RUN,
    output logic CORE_CLOCK_EN,
    output logic SRAM_CLOCK_EN,
    output logic CFG_REFUSED,
    output logic MEM_TECH_SDRAM
);
    logic [STRAP_W-1:0] strap_s1_reg, strap_s2_reg;
    logic [NUM_MASTERS-1:0] req_s1_reg, req_s2_reg;
    logic clkrun_s1_reg, clkrun_s2_reg, act_s1_reg, act_s2_reg;
    logic tech_s1_reg, tech_s2_reg;
    logic captured_reg;
    logic [3:0] idle_cnt_reg;
    logic [NUM_MASTERS-1:0] gnt_reg;
    logic [2:0] owner_reg;
    arb_state_e arb_reg;
    logic cfg_cycle_reg;
    logic [31:0] idsel_reg;
    logic [NUM_BANKS-1:0] cke_reg;

    // Synchronise every pin from the partner end
    always_ff @(posedge CLOCK) begin
        strap_s1_reg <= LINK.strap_pins;
        strap_s2_reg <= strap_s1_reg;
        req_s1_reg <= LINK.req;
        req_s2_reg <= req_s1_reg;
        clkrun_s1_reg <= LINK.clkrun_level;
        clkrun_s2_reg <= clkrun_s1_reg;
        act_s1_reg <= LINK.pci_activity;
        act_s2_reg <= act_s1_reg;
        tech_s1_reg <= LINK.sdram_rows;
        tech_s2_reg <= tech_s1_reg;
    end

    // Straps caught on the first edge after release, then frozen
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            captured_reg <= 1'b0;
            HOST_FREQ_66 <= 1'b1;
            QUEUE_DEPTH <= QUEUE_DEPTH_MAX;
            QUICK_START <= 1'b0;
            GRAPHICS_ENABLE <= 1'b1;
            STANDARD_MEM_MODE <= 1'b1;
            FSB_BUFFERS <= 1'b0;
            MEM_TECH_SDRAM <= 1'b1;
        end else if (!captured_reg) begin
            captured_reg <= 1'b1;
            // No override exists: host frequency fixed
            HOST_FREQ_66 <= 1'b1;
            // Active-low strap: unstrapped (high) gives deepest queue
            QUEUE_DEPTH <= strap_s2_reg[QUEUE_DEPTH_BIT] ? QUEUE_DEPTH_MAX : QUEUE_DEPTH_MIN;
            QUICK_START <= strap_s2_reg[QUICK_START_BIT];
            GRAPHICS_ENABLE <= ~strap_s2_reg[GRAPHICS_DIS_BIT];
            // Only standard mode is built, so the strap cannot leave it
            STANDARD_MEM_MODE <= 1'b1;
            FSB_BUFFERS <= strap_s2_reg[HOST_BUF_BIT];
            // One technology latched for all rows
            MEM_TECH_SDRAM <= tech_s2_reg;
        end
    end

    // Round-robin arbiter over five request and grant pairs
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            arb_reg <= ARB_IDLE;
            gnt_reg <= GNT_RESET;
            owner_reg <= 3'h0;
        end else begin
            unique case (arb_reg)
                ARB_IDLE, ARB_PARK: begin
                    gnt_reg <= GNT_RESET;
                    arb_reg <= ARB_IDLE;
                    for (int k = 1; k <= NUM_MASTERS; k++) begin
                        int idx;
                        idx = (int'(owner_reg) + k) % NUM_MASTERS;
                        if (req_s2_reg[idx] && arb_reg == ARB_IDLE &&
                                gnt_reg == GNT_RESET && PCI_CLOCK_RUN) begin
                            gnt_reg <= NUM_MASTERS'(1) << idx;
                            owner_reg <= 3'(idx);
                            arb_reg <= ARB_GRANT;
                            break;
                        end
                    end
                end
                ARB_GRANT: begin
                    // Grant held until owner drops its request
                    if (!req_s2_reg[owner_reg]) begin
                        gnt_reg <= GNT_RESET;
                        arb_reg <= ARB_PARK;
                    end
                end
            endcase
        end
    end
    assign LINK.gnt = gnt_reg;

    // Configuration selects: only mechanism one decode, self and graphics excluded
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            cfg_cycle_reg <= 1'b0;
            idsel_reg <= 32'h0;
            CFG_REFUSED <= 1'b0;
        end else begin
            cfg_cycle_reg <= 1'b0;
            idsel_reg <= 32'h0;
            CFG_REFUSED <= 1'b0;
            if (CFG_REQ) begin
                // Device n maps to line 11+n; lines beyond 31 do not exist
                if (int'(CFG_DEVICE) + IDSEL_LOW < IDSEL_FIRST_EXT ||
                        int'(CFG_DEVICE) + IDSEL_LOW > 31) begin
                    CFG_REFUSED <= 1'b1;
                end else begin
                    cfg_cycle_reg <= 1'b1;
                    idsel_reg <= 32'h1 << (int'(CFG_DEVICE) + IDSEL_LOW);
                end
            end
        end
    end
    assign LINK.cfg_cycle = cfg_cycle_reg;
    assign LINK.idsel = idsel_reg;

    // Clock-run: keep PCI clock while any agent pulls the line low
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            PCI_CLOCK_RUN <= 1'b1;
        end else begin
            PCI_CLOCK_RUN <= ~clkrun_s2_reg | act_s2_reg | (|req_s2_reg);
        end
    end
    // Bridge never needs to hold the line itself here
    assign LINK.clkrun_dev_oe = 1'b0;

    // Internal clock gate after a short idle run, to avoid chatter
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            idle_cnt_reg <= 4'h0;
            CORE_CLOCK_EN <= 1'b1;
        end else if (HOST_ACTIVITY || act_s2_reg || (|req_s2_reg)) begin
            idle_cnt_reg <= 4'h0;
            CORE_CLOCK_EN <= 1'b1;
        end else if (idle_cnt_reg != IDLE_GATE_CYCLES) begin
            idle_cnt_reg <= idle_cnt_reg + 4'h1;
        end else begin
            CORE_CLOCK_EN <= 1'b0;
        end
    end

    // Second-level SRAM clock parked in stop-clock mode
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            SRAM_CLOCK_EN <= 1'b1;
        end else begin
            SRAM_CLOCK_EN <= ~STOP_CLOCK_REQ;
        end
    end

    // One enable per bank, six banks only
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            cke_reg <= '0;
        end else begin
            cke_reg <= BANK_ENABLE;
        end
    end
    assign LINK.bank_cke = cke_reg;
endmodule // bridge_ctrl

// file: bridge_ctrl_bench.sv
// Self-checking bench joining the bridge end to its partner end
module bridge_ctrl_bench import bridge_ctrl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLOCK = 1'b0, RST = 1'b1, host_activity = 1'b0, stop_clock_req = 1'b0;
    logic cfg_req = 1'b0, need_clock = 1'b0, graphics_off = 1'b0, rows_sdram = 1'b1;
    logic [4:0] cfg_device = 5'h00;
    logic [NUM_BANKS-1:0] bank_enable = '0;
    logic [NUM_MASTERS-1:0] master_wants = '0;
    logic host_freq_66, quick_start, graphics_enable, standard_mem_mode, fsb_buffers;
    logic pci_clock_run, core_clock_en, sram_clock_en, cfg_refused, mem_tech_sdram;
    logic [3:0] queue_depth;
    logic [NUM_BANKS-1:0] bank_cke_seen;
    logic [NUM_MASTERS-1:0] master_owns;
    logic selected_south;
    int errors = 0, cmp_count = 0, cycles = 0;

    // 50 ns period
    always #25 CLOCK = ~CLOCK;

    bridge_link_if link();
    bridge_ctrl u_bridge_ctrl (.CLOCK(CLOCK), .RST(RST), .LINK(link),
        .HOST_ACTIVITY(host_activity), .STOP_CLOCK_REQ(stop_clock_req), .CFG_REQ(cfg_req),
        .CFG_DEVICE(cfg_device), .BANK_ENABLE(bank_enable), .HOST_FREQ_66(host_freq_66),
        .QUEUE_DEPTH(queue_depth), .QUICK_START(quick_start),
        .GRAPHICS_ENABLE(graphics_enable), .STANDARD_MEM_MODE(standard_mem_mode),
        .FSB_BUFFERS(fsb_buffers), .PCI_CLOCK_RUN(pci_clock_run),
        .CORE_CLOCK_EN(core_clock_en), .SRAM_CLOCK_EN(sram_clock_en),
        .CFG_REFUSED(cfg_refused), .MEM_TECH_SDRAM(mem_tech_sdram));
    bridge_partner u_bridge_partner (.CLOCK(CLOCK), .RST(RST), .LINK(link),
        .MASTER_WANTS(master_wants), .NEED_CLOCK(need_clock), .GRAPHICS_OFF(graphics_off),
        .ROWS_SDRAM(rows_sdram), .MASTER_OWNS(master_owns), .SELECTED_SOUTH(selected_south),
        .BANK_CKE_SEEN(bank_cke_seen));
    bridge_ctrl_monitor u_bridge_ctrl_monitor (.CLOCK(CLOCK), .RST(RST), .req(link.req),
        .gnt(link.gnt),
        .clkrun_level(link.clkrun_level), .cfg_cycle(link.cfg_cycle), .idsel(link.idsel));

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Long reset lets the pin synchronisers settle before capture
    task automatic do_reset();
        @(negedge CLOCK) RST = 1'b1;
        repeat (10) @(negedge CLOCK);
        RST = 1'b0;
        repeat (2) @(negedge CLOCK);
    endtask

    // Straps take effect at reset and ignore later pin changes
    task automatic strap_case(input logic gfx_off, input logic sdram);
        graphics_off = gfx_off;
        rows_sdram = sdram;
        do_reset();
        check(host_freq_66, 1'b1, "host freq");
        check(queue_depth, QUEUE_DEPTH_MAX, "queue depth");
        check(quick_start, 1'b1, "quick start");
        check(graphics_enable, !gfx_off, "graphics port");
        check(standard_mem_mode, 1'b1, "memory mode");
        check(fsb_buffers, 1'b1, "host buffers");
        check(mem_tech_sdram, sdram, "row technology");
        graphics_off = !gfx_off;
        rows_sdram = !sdram;
        repeat (5) @(negedge CLOCK);
        check(graphics_enable, !gfx_off, "graphics held");
        check(mem_tech_sdram, sdram, "technology held");
    endtask

    // Every device number, including those that must be refused
    task automatic cfg_scan();
        for (int n = 0; n < 32; n++) begin
            cfg_req = 1'b1;
            cfg_device = n[4:0];
            @(negedge CLOCK);
            cfg_req = 1'b0;
            if (n < 2 || n > 20) begin
                check(cfg_refused, 1'b1, "config refused");
                check(link.cfg_cycle, 1'b0, "no config cycle");
            end else begin
                check(link.cfg_cycle, 1'b1, "config cycle");
                check(link.idsel, 32'h1 << (11 + n), "select line");
            end
            @(negedge CLOCK);
            // Partner flags its own select one cycle after the config cycle
            check(selected_south, n == IDSEL_SOUTH - IDSEL_LOW, "south select");
        end
    endtask

    // All five ask at once; each owner drops out after its grant
    task automatic arb_round();
        logic [NUM_MASTERS-1:0] served;
        logic [NUM_MASTERS-1:0] owner;
        int t;
        served = '0;
        master_wants = 5'h1f;
        repeat (5) begin
            for (t = 0; t < 20 && link.gnt == '0; t++) @(negedge CLOCK);
            check($countones(link.gnt), 1, "one grant");
            check(pci_clock_run, 1'b1, "clock runs for request");
            owner = link.gnt;
            served = served | owner;
            // Partner sees the grant through three flops; grant must stand meanwhile
            repeat (3) @(negedge CLOCK);
            check(link.gnt, owner, "grant held");
            check(master_owns, owner, "owner sees grant");
            master_wants = master_wants & ~owner;
            for (t = 0; t < 20 && link.gnt != '0; t++) @(negedge CLOCK);
        end
        check(served, 5'h1f, "all masters served");
    endtask

    // Clock-run, idle gating, cache clock stop and bank enables
    task automatic clock_gate();
        int t;
        need_clock = 1'b1;
        repeat (5) @(negedge CLOCK);
        check(pci_clock_run, 1'b1, "clock run held");
        need_clock = 1'b0;
        // Idle gate may drop before clock-run does, so wait for both
        for (t = 0; t < 30 && (core_clock_en !== 1'b0 || pci_clock_run !== 1'b0); t++) begin
            @(negedge CLOCK);
        end
        check(pci_clock_run, 1'b0, "pci clock stopped");
        check(core_clock_en, 1'b0, "core clock gated");
        host_activity = 1'b1;
        stop_clock_req = 1'b1;
        bank_enable = 6'h2a;
        repeat (2) @(negedge CLOCK);
        check(core_clock_en, 1'b1, "core clock restored");
        check(sram_clock_en, 1'b0, "sram clock stopped");
        stop_clock_req = 1'b0;
        repeat (4) @(negedge CLOCK);
        check(sram_clock_en, 1'b1, "sram clock running");
        check(link.bank_cke, 6'h2a, "bank enables");
        check(bank_cke_seen, 6'h2a, "bank enables seen");
    endtask

    task automatic report_and_stop();
        if (errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Hang guard, well above the fewer than two hundred cycles needed
    always @(posedge CLOCK) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            $display("MISMATCH at %0t: timeout", $time);
            report_and_stop();
        end
    end

    initial begin
        strap_case(1'b0, 1'b1);
        cfg_scan();
        arb_round();
        clock_gate();
        strap_case(1'b1, 1'b0);
        report_and_stop();
    end
endmodule // bridge_ctrl_bench

// file: bridge_ctrl_monitor.sv
// Concurrent checks on the signals of the bridge link
module bridge_ctrl_monitor
    import bridge_ctrl_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic [NUM_MASTERS-1:0] req,
    input wire logic [NUM_MASTERS-1:0] gnt,
    input wire logic clkrun_level,
    input wire logic cfg_cycle,
    input wire logic [31:0] idsel
);
    // One domain, so clock and reset are given once
    default clocking @(posedge CLOCK);
    endclocking
    default disable iff (RST);

    // Arbiter: one owner, tied to a recent request, held until released
    chk_gnt_onehot: assert property ($onehot0(gnt))
        else $error("more than one grant at once");
    chk_gnt_has_req: assert property (|gnt |-> |(gnt & ($past(req, 2) | $past(req, 3))))
        else $error("grant without a matching request");
    chk_gnt_held: assert property ((|gnt && |$past(gnt)) |-> gnt == $past(gnt))
        else $error("grant moved while held");
    chk_gnt_release: assert property (($fell(|req) && |gnt) |-> ##[1:3] gnt == '0)
        else $error("grant not withdrawn after request dropped");
    chk_gnt_park: assert property ($fell(|gnt) |=> gnt == '0)
        else $error("no idle cycle between owners");

    // Configuration selects: one line, never the bridge or graphics line
    chk_cfg_onehot: assert property (cfg_cycle |-> $onehot(idsel))
        else $error("config select not one-hot");
    chk_cfg_not_self: assert property (cfg_cycle |-> !idsel[IDSEL_SELF])
        else $error("bridge select line asserted");
    chk_cfg_gfx_line: assert property (cfg_cycle |-> !idsel[IDSEL_GRAPHICS])
        else $error("graphics select line used");
    chk_cfg_low_lines: assert property (cfg_cycle |-> idsel[10:0] == 11'h000)
        else $error("select below the usable range");

    // Main scenarios reached
    cov_grant: cover property ($rose(|gnt));
    cov_south: cover property (cfg_cycle && idsel[IDSEL_SOUTH]);
    cov_clkrun: cover property (!clkrun_level);
endmodule // bridge_ctrl_monitor

// file: bridge_ctrl_pkg.sv
// Shared constants and types for the host bridge control ends
package bridge_ctrl_pkg;
    // Strap positions on the memory address bus
    localparam int STRAP_W = 14;
    localparam int HOST_FREQ_BIT = 12;
    localparam int QUEUE_DEPTH_BIT = 11;
    localparam int QUICK_START_BIT = 10;
    localparam int GRAPHICS_DIS_BIT = 9;
    localparam int MEM_CONFIG_BIT = 7;
    localparam int HOST_BUF_BIT = 6;
    // Values selected by the straps
    localparam int HOST_FREQ_MHZ = 66;
    localparam logic [3:0] QUEUE_DEPTH_MAX = 4'h8;
    localparam logic [3:0] QUEUE_DEPTH_MIN = 4'h1;
    // Arbitration and configuration
    localparam int NUM_MASTERS = 5;
    localparam int IDSEL_LOW = 11;
    localparam int IDSEL_SELF = 11;
    localparam int IDSEL_GRAPHICS = 12;
    localparam int IDSEL_FIRST_EXT = 13;
    localparam int IDSEL_SOUTH = 18;
    localparam logic [1:0] CFG_MECH_ONE = 2'h1;
    // Memory limits
    localparam int NUM_BANKS = 6;
    localparam int SDRAM_MHZ = 66;
    localparam int L2_SIZE_KB = 512;
    localparam int MGMT_MEM_MAX_KB = 1024;
    // Idle cycles before the internal clock is gated
    localparam logic [3:0] IDLE_GATE_CYCLES = 4'h8;
    // Reset values and arbiter states
    localparam logic [4:0] GNT_RESET = 5'h00;
    typedef enum logic [2:0] {
        ARB_IDLE = 3'b001,
        ARB_GRANT = 3'b010,
        ARB_PARK = 3'b100
    } arb_state_e;
endpackage

// file: bridge_link_if.sv
// Link between the bridge control end and its PCI and DRAM partner end
interface bridge_link_if;
    import bridge_ctrl_pkg::*;
    logic [STRAP_W-1:0] strap_pins;
    logic [NUM_MASTERS-1:0] req;
    logic [NUM_MASTERS-1:0] gnt;
    logic clkrun_in_oe;
    logic clkrun_dev_oe;
    logic clkrun_level;
    logic cfg_cycle;
    logic [31:0] idsel;
    logic [NUM_BANKS-1:0] bank_cke;
    logic pci_activity;
    logic sdram_rows;
    // Open-drain wire: low while either end drives
    assign clkrun_level = ~(clkrun_in_oe | clkrun_dev_oe);
    modport bridge (
        input strap_pins, req, clkrun_level, pci_activity, sdram_rows,
        output gnt, clkrun_dev_oe, cfg_cycle, idsel, bank_cke
    );
    modport partner (
        output strap_pins, req, clkrun_in_oe, pci_activity, sdram_rows,
        input gnt, clkrun_level, cfg_cycle, idsel, bank_cke
    );
endinterface

// file: bridge_partner.sv
// Partner end: PCI agents and DRAM rows facing the bridge
module bridge_partner
    import bridge_ctrl_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST,
    bridge_link_if.partner LINK,
    input wire logic [NUM_MASTERS-1:0] MASTER_WANTS,
    input wire logic NEED_CLOCK,
    input wire logic GRAPHICS_OFF,
    input wire logic ROWS_SDRAM,
    output logic [NUM_MASTERS-1:0] MASTER_OWNS,
    output logic SELECTED_SOUTH,
    output logic [NUM_BANKS-1:0] BANK_CKE_SEEN
);
    logic [NUM_MASTERS-1:0] gnt_s1_reg, gnt_s2_reg;
    logic [NUM_MASTERS-1:0] req_reg;
    logic clkrun_oe_reg;
    logic tech_reg;

    // Straps: unstrapped lines float high; module fixes quick start and buffers
    always_comb begin
        LINK.strap_pins = '1;
        LINK.strap_pins[GRAPHICS_DIS_BIT] = GRAPHICS_OFF;
    end

    // Requests and clock-run from the agents
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            req_reg <= '0;
            clkrun_oe_reg <= 1'b0;
        end else begin
            req_reg <= MASTER_WANTS;
            clkrun_oe_reg <= NEED_CLOCK | (|MASTER_WANTS);
        end
    end

    // Row technology is fixed wiring: it follows through reset so capture sees it
    always_ff @(posedge CLOCK) begin
        tech_reg <= ROWS_SDRAM;
    end
    assign LINK.req = req_reg;
    assign LINK.clkrun_in_oe = clkrun_oe_reg;
    assign LINK.pci_activity = |req_reg;
    assign LINK.sdram_rows = tech_reg;

    // Observe grants, southbridge select and bank enables
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            gnt_s1_reg <= '0;
            gnt_s2_reg <= '0;
            MASTER_OWNS <= '0;
            SELECTED_SOUTH <= 1'b0;
            BANK_CKE_SEEN <= '0;
        end else begin
            gnt_s1_reg <= LINK.gnt;
            gnt_s2_reg <= gnt_s1_reg;
            MASTER_OWNS <= gnt_s2_reg;
            SELECTED_SOUTH <= LINK.cfg_cycle & LINK.idsel[IDSEL_SOUTH];
            BANK_CKE_SEEN <= LINK.bank_cke;
        end
    end
endmodule // bridge_partner
